// *** hdl/pdc_bank.sv ***
// divider configuration bank: byte registers plus the dividers they steer
// assumes a simple byte register port on clk_sys; clock pins are asynchronous
`timescale 1ns/100ps
`include "pdc_defs.svh"

module pdc_bank
  import pdc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // clock pins, asynchronous
  input wire logic clock_input_one,
  input wire logic clock_input_two,
  input wire logic vco_clk,
  // divided ticks
  output logic in1_pre_div_tick,
  output logic in2_pre_div_tick,
  output logic phase_det_fb_tick,
  output logic clock_output_two_tick
);
  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  pdc_byte_t out2_div_mid_byte_r;
  pdc_byte_t out2_div_low_byte_r;
  pdc_byte_t fb_hs_code_and_ls_top_r;
  pdc_byte_t fb_ls_div_mid_byte_r;
  pdc_byte_t fb_ls_div_low_byte_r;
  pdc_byte_t in1_div_top_bits_r;
  pdc_byte_t in1_div_mid_byte_r;
  pdc_byte_t in1_div_low_byte_r;
  pdc_byte_t in2_div_top_bits_r;
  pdc_byte_t in2_div_mid_byte_r;
  pdc_byte_t in2_div_low_byte_r;

  function automatic logic hit(input pdc_addr_t a, input pdc_addr_t ofs);
    hit = (a == ofs);
  endfunction

  wire wr_out2_mid = reg_wr & hit(reg_addr, `PDC_OFS_OUT2_MID);
  wire wr_out2_low = reg_wr & hit(reg_addr, `PDC_OFS_OUT2_LOW);
  wire wr_fb_top = reg_wr & hit(reg_addr, `PDC_OFS_FB_HS_TOP);
  wire wr_fb_mid = reg_wr & hit(reg_addr, `PDC_OFS_FB_MID);
  wire wr_fb_low = reg_wr & hit(reg_addr, `PDC_OFS_FB_LOW);
  wire wr_in1_top = reg_wr & hit(reg_addr, `PDC_OFS_IN1_TOP);
  wire wr_in1_mid = reg_wr & hit(reg_addr, `PDC_OFS_IN1_MID);
  wire wr_in1_low = reg_wr & hit(reg_addr, `PDC_OFS_IN1_LOW);
  wire wr_in2_top = reg_wr & hit(reg_addr, `PDC_OFS_IN2_TOP);
  wire wr_in2_mid = reg_wr & hit(reg_addr, `PDC_OFS_IN2_MID);
  wire wr_in2_low = reg_wr & hit(reg_addr, `PDC_OFS_IN2_LOW);

  // bit 4 of the feedback register is reserved and never stored
  wire [7:0] fb_top_wmask = 8'hEF;
  wire [7:0] in_top_wmask = 8'h07;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      out2_div_mid_byte_r <= `PDC_RST_OUT2_MID;
      out2_div_low_byte_r <= `PDC_RST_OUT2_LOW;
      fb_hs_code_and_ls_top_r <= `PDC_RST_FB_HS_TOP;
      fb_ls_div_mid_byte_r <= `PDC_RST_FB_MID;
      fb_ls_div_low_byte_r <= `PDC_RST_FB_LOW;
      in1_div_top_bits_r <= `PDC_RST_IN1_TOP;
      in1_div_mid_byte_r <= `PDC_RST_IN1_MID;
      in1_div_low_byte_r <= `PDC_RST_IN1_LOW;
      in2_div_top_bits_r <= `PDC_RST_IN2_TOP;
      in2_div_mid_byte_r <= `PDC_RST_IN2_MID;
      in2_div_low_byte_r <= `PDC_RST_IN2_LOW;
    end else begin
      if (wr_out2_mid) out2_div_mid_byte_r <= reg_wdata;
      if (wr_out2_low) out2_div_low_byte_r <= reg_wdata;
      if (wr_fb_top) fb_hs_code_and_ls_top_r <= reg_wdata & fb_top_wmask;
      if (wr_fb_mid) fb_ls_div_mid_byte_r <= reg_wdata;
      if (wr_fb_low) fb_ls_div_low_byte_r <= reg_wdata;
      if (wr_in1_top) in1_div_top_bits_r <= reg_wdata & in_top_wmask;
      if (wr_in1_mid) in1_div_mid_byte_r <= reg_wdata;
      if (wr_in1_low) in1_div_low_byte_r <= reg_wdata;
      if (wr_in2_top) in2_div_top_bits_r <= reg_wdata & in_top_wmask;
      if (wr_in2_mid) in2_div_mid_byte_r <= reg_wdata;
      if (wr_in2_low) in2_div_low_byte_r <= reg_wdata;
    end
  end

  // ----------------------------------------
  // read-back
  // ----------------------------------------
  // every register is passed in so the mux follows a write, not only an address change
  wire [87:0] reg_image = {out2_div_mid_byte_r, out2_div_low_byte_r, fb_hs_code_and_ls_top_r,
                           fb_ls_div_mid_byte_r, fb_ls_div_low_byte_r, in1_div_top_bits_r,
                           in1_div_mid_byte_r, in1_div_low_byte_r, in2_div_top_bits_r,
                           in2_div_mid_byte_r, in2_div_low_byte_r};

  function automatic pdc_byte_t read_mux(input pdc_addr_t a, input logic [87:0] img);
    case (a)
      `PDC_OFS_OUT2_MID: read_mux = img[87:80];
      `PDC_OFS_OUT2_LOW: read_mux = img[79:72];
      `PDC_OFS_FB_HS_TOP: read_mux = img[71:64];
      `PDC_OFS_FB_MID: read_mux = img[63:56];
      `PDC_OFS_FB_LOW: read_mux = img[55:48];
      `PDC_OFS_IN1_TOP: read_mux = img[47:40];
      `PDC_OFS_IN1_MID: read_mux = img[39:32];
      `PDC_OFS_IN1_LOW: read_mux = img[31:24];
      `PDC_OFS_IN2_TOP: read_mux = img[23:16];
      `PDC_OFS_IN2_MID: read_mux = img[15:8];
      `PDC_OFS_IN2_LOW: read_mux = img[7:0];
      default: read_mux = 8'h00;
    endcase
  endfunction

  wire [7:0] rdata_nxt = read_mux(reg_addr, reg_image);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // field assembly
  // ----------------------------------------
  // upper output-two nibble lives elsewhere; this bank covers bits 15:0
  wire [`PDC_OUT2_W-1:0] out2_lowspeed_div = {out2_div_mid_byte_r, out2_div_low_byte_r};
  wire [2:0] fb_highspeed_div = fb_hs_code_and_ls_top_r[`PDC_FB_HS_MSB:`PDC_FB_HS_LSB];
  // terminal = code + 3 gives a ratio of code + 4, 4 through 11
  wire [3:0] fb_hs_terminal = {1'b0, fb_highspeed_div} + `PDC_FB_HS_OFFSET;
  wire [`PDC_FB_W-1:0] fb_lowspeed_div = {fb_hs_code_and_ls_top_r[`PDC_FB_TOP_MSB:0],
                                          fb_ls_div_mid_byte_r, fb_ls_div_low_byte_r};
  wire [`PDC_IN_W-1:0] in1_pre_div = {in1_div_top_bits_r[`PDC_IN_TOP_MSB:0],
                                      in1_div_mid_byte_r, in1_div_low_byte_r};
  wire [`PDC_IN_W-1:0] in2_pre_div = {in2_div_top_bits_r[`PDC_IN_TOP_MSB:0],
                                      in2_div_mid_byte_r, in2_div_low_byte_r};

  // ----------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------
  logic [2:0] ck1_sync_r;
  logic [2:0] ck2_sync_r;
  logic [2:0] vco_sync_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ck1_sync_r <= 3'h0;
      ck2_sync_r <= 3'h0;
      vco_sync_r <= 3'h0;
    end else begin
      ck1_sync_r <= {ck1_sync_r[1:0], clock_input_one};
      ck2_sync_r <= {ck2_sync_r[1:0], clock_input_two};
      vco_sync_r <= {vco_sync_r[1:0], vco_clk};
    end
  end

  // bit 0 is the metastable stage; edges are taken from bits 2:1 only
  wire ck1_rise = ck1_sync_r[1] & ~ck1_sync_r[2];
  wire ck2_rise = ck2_sync_r[1] & ~ck2_sync_r[2];
  wire vco_rise = vco_sync_r[1] & ~vco_sync_r[2];
  // pins must toggle well below clk_sys/2 or edges are dropped

  // ----------------------------------------
  // dividers
  // ----------------------------------------
  logic fb_hs_tick;

  pdc_divider #(.W(`PDC_IN_W)) u_in1_div (
    .clk_sys(clk_sys),
    .srst(srst),
    .tick_in(ck1_rise),
    .terminal(in1_pre_div),
    .tick_out(in1_pre_div_tick)
  );

  pdc_divider #(.W(`PDC_IN_W)) u_in2_div (
    .clk_sys(clk_sys),
    .srst(srst),
    .tick_in(ck2_rise),
    .terminal(in2_pre_div),
    .tick_out(in2_pre_div_tick)
  );

  pdc_divider #(.W(4)) u_fb_hs_div (
    .clk_sys(clk_sys),
    .srst(srst),
    .tick_in(vco_rise),
    .terminal(fb_hs_terminal),
    .tick_out(fb_hs_tick)
  );

  // even-ratio restriction is software's; odd fields still divide by field + 1
  pdc_divider #(.W(`PDC_FB_W)) u_fb_ls_div (
    .clk_sys(clk_sys),
    .srst(srst),
    .tick_in(fb_hs_tick),
    .terminal(fb_lowspeed_div),
    .tick_out(phase_det_fb_tick)
  );

  // zero divides by one; odd fields give the even ratios software is limited to
  pdc_divider #(.W(`PDC_OUT2_W)) u_out2_div (
    .clk_sys(clk_sys),
    .srst(srst),
    .tick_in(vco_rise),
    .terminal(out2_lowspeed_div),
    .tick_out(clock_output_two_tick)
  );
endmodule

// *** hdl/pdc_defs.svh ***
// register offsets, field positions, reset values for the divider configuration bank
// assumes inclusion by bare name from design files only
`ifndef PDC_DEFS_SVH
`define PDC_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PDC_OFS_OUT2_MID 8'h23
`define PDC_OFS_OUT2_LOW 8'h24
`define PDC_OFS_FB_HS_TOP 8'h28
`define PDC_OFS_FB_MID 8'h29
`define PDC_OFS_FB_LOW 8'h2A
`define PDC_OFS_IN1_TOP 8'h2B
`define PDC_OFS_IN1_MID 8'h2C
`define PDC_OFS_IN1_LOW 8'h2D
`define PDC_OFS_IN2_TOP 8'h2E
`define PDC_OFS_IN2_MID 8'h2F
`define PDC_OFS_IN2_LOW 8'h30

// ----------------------------------------
// reset values
// ----------------------------------------
`define PDC_RST_OUT2_MID 8'h00
`define PDC_RST_OUT2_LOW 8'h31
`define PDC_RST_FB_HS_TOP 8'hC0
`define PDC_RST_FB_MID 8'h00
`define PDC_RST_FB_LOW 8'hF9
`define PDC_RST_IN1_TOP 8'h00
`define PDC_RST_IN1_MID 8'h00
`define PDC_RST_IN1_LOW 8'h09
`define PDC_RST_IN2_TOP 8'h00
`define PDC_RST_IN2_MID 8'h00
`define PDC_RST_IN2_LOW 8'h00

// ----------------------------------------
// field positions and widths
// ----------------------------------------
`define PDC_FB_HS_MSB 7
`define PDC_FB_HS_LSB 5
`define PDC_FB_TOP_MSB 3
`define PDC_IN_TOP_MSB 2
`define PDC_FB_HS_OFFSET 4'h3
`define PDC_OUT2_W 16
`define PDC_FB_W 20
`define PDC_IN_W 19

`endif

// *** hdl/pdc_pkg.sv ***
// types shared by the divider configuration bank
// assumes pdc_defs.svh is available on the include path
package pdc_pkg;
  typedef logic [7:0] pdc_byte_t;
  typedef logic [7:0] pdc_addr_t;
endpackage

// *** hdl/pdc_divider.sv ***
// programmable tick divider: one output pulse per (terminal+1) input ticks
// assumes tick_in is a one-cycle pulse on clk_sys
`timescale 1ns/100ps
module pdc_divider
  import pdc_pkg::*;
#(
  parameter int W = 20
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // ticks
  input wire logic tick_in,
  input wire logic [W-1:0] terminal,
  output logic tick_out
);
  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  // >= so a terminal lowered below the count wraps at once instead of running 2^W ticks
  wire at_end = (count_r >= terminal);

  assign count_nxt = at_end ? '0 : count_r + {{(W-1){1'b0}}, 1'b1};

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_r <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in & at_end;
      if (tick_in) begin
        count_r <= count_nxt;
      end
    end
  end
endmodule

// *** dv/pdc_bank_monitor.sv ***
// assertions on the divider bank register port and tick outputs
// assumes it is bound to pdc_bank and sees only its ports
`timescale 1ns/100ps
module pdc_bank_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // ticks
  input wire logic in1_pre_div_tick,
  input wire logic in2_pre_div_tick,
  input wire logic phase_det_fb_tick,
  input wire logic clock_output_two_tick
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  reset_quiet_a: assert property (disable iff (1'b0) srst |=> reg_rdata == 8'h00 && !phase_det_fb_tick)
    else $error("outputs not quiet after reset");
  hs_reset_a: assert property ($fell(srst) && reg_addr == 8'h28 && !reg_wr |=> reg_rdata == 8'hC0)
    else $error("feedback code register wrong after reset");
  write_read_a: assert property (reg_wr && reg_addr == 8'h24 ##1 !reg_wr && reg_addr == 8'h24 |=> reg_rdata == $past(reg_wdata, 2))
    else $error("written byte not read back");
  fb_rsvd_a: assert property (reg_addr == 8'h28 |=> reg_rdata[4] == 1'b0)
    else $error("reserved bit set");
  in_rsvd_a: assert property (reg_addr == 8'h2B || reg_addr == 8'h2E |=> reg_rdata[7:3] == 5'h00)
    else $error("input divider top bits too wide");
  unmapped_zero_a: assert property (reg_addr == 8'h25 || reg_addr == 8'h31 |=> reg_rdata == 8'h00)
    else $error("unmapped address reads nonzero");
  in1_pulse_a: assert property (in1_pre_div_tick |=> !in1_pre_div_tick)
    else $error("input one tick too long");
  out2_pulse_a: assert property (clock_output_two_tick |=> !clock_output_two_tick)
    else $error("output two tick too long");
  // the cascade never gives fewer than four pin edges between ticks
  fb_spacing_a: assert property (phase_det_fb_tick |=> !phase_det_fb_tick [*7])
    else $error("feedback ticks too close");
endmodule

// *** dv/pdc_bank_bench.sv ***
// self-checking bench for the divider configuration bank
// assumes the monitor is compiled first; pins toggle at clk_sys/6, below clk_sys/4
`timescale 1ns/100ps
module pdc_bank_bench;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h28;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [2:0] pins = 3'h0;
  wire [7:0] reg_rdata;
  wire [3:0] tk;
  int cnt [4];
  int mismatches = 0;
  int tests_run = 0;
  pdc_bank i_pdc_bank (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .clock_input_one(pins[0]), .clock_input_two(pins[1]),
    .vco_clk(pins[2]), .in1_pre_div_tick(tk[0]), .in2_pre_div_tick(tk[1]), .phase_det_fb_tick(tk[2]),
    .clock_output_two_tick(tk[3]));
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (srst) begin
      cnt <= '{0, 0, 0, 0};
    end else begin
      for (int i = 0; i < 4; i++) if (tk[i] === 1'b1) cnt[i] <= cnt[i] + 1;
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(negedge clk_sys);
    reg_addr = a;
    @(negedge clk_sys);
    chk($sformatf("reg %h", a), exp, reg_rdata);
  endtask
  task automatic do_reset();
    @(negedge clk_sys);
    srst = 1'b1;
    reg_addr = 8'h28;
    repeat (4) @(negedge clk_sys);
    srst = 1'b0;
  endtask
  // pin period of six cycles keeps every edge visible through the synchroniser
  task automatic pls(logic [2:0] m, int n);
    repeat (n) begin
      pins = m;
      repeat (3) @(negedge clk_sys);
      pins = 3'h0;
      repeat (3) @(negedge clk_sys);
    end
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic counts(int a, int b, int c, int d);
    chk("in1 ticks", 8'(a), 8'(cnt[0]));
    chk("in2 ticks", 8'(b), 8'(cnt[1]));
    chk("fb ticks", 8'(c), 8'(cnt[2]));
    chk("out2 ticks", 8'(d), 8'(cnt[3]));
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] ad [12] = '{8'h23, 8'h24, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h25};
    logic [7:0] ex [12] = '{8'h00, 8'h31, 8'hC0, 8'h00, 8'hF9, 8'h00, 8'h00, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 12; i++) rd(ad[i], ex[i]);
    $display("reset values done");
  endtask
  task automatic t_fields();
    wr(8'h28, 8'hFF);
    rd(8'h28, 8'hEF);
    wr(8'h2B, 8'hFF);
    rd(8'h2B, 8'h07);
    wr(8'h2E, 8'hFF);
    rd(8'h2E, 8'h07);
    wr(8'h24, 8'h55);
    rd(8'h24, 8'h55);
    wr(8'h25, 8'hAA);
    rd(8'h25, 8'h00);
    $display("field access done");
  endtask
  task automatic t_inputs();
    do_reset();
    wr(8'h2D, 8'h02);
    wr(8'h30, 8'h03);
    pls(3'h3, 12);
    counts(4, 3, 0, 0);
    do_reset();
    wr(8'h2D, 8'h00);
    pls(3'h3, 5);
    counts(5, 5, 0, 0);
    $display("input dividers done");
  endtask
  task automatic t_vco();
    do_reset();
    wr(8'h28, 8'h00);
    wr(8'h2A, 8'h01);
    wr(8'h24, 8'h03);
    pls(3'h4, 24);
    counts(0, 0, 3, 6);
    do_reset();
    wr(8'h28, 8'hE0);
    wr(8'h2A, 8'h01);
    wr(8'h24, 8'h00);
    pls(3'h4, 44);
    counts(0, 0, 2, 44);
    $display("vco dividers done");
  endtask
  initial begin
    repeat (4) @(negedge clk_sys);
    srst = 1'b0;
    t_reset();
    t_fields();
    t_inputs();
    t_vco();
    wrap_up();
  end
  initial begin
    repeat (6000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end
endmodule
bind pdc_bank pdc_bank_monitor i_pdc_bank_monitor (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .in1_pre_div_tick(in1_pre_div_tick),
  .in2_pre_div_tick(in2_pre_div_tick), .phase_det_fb_tick(phase_det_fb_tick),
  .clock_output_two_tick(clock_output_two_tick));
